//--- core/out_guard_pkg.sv
// Shared constants and carrier types for the timer output disable guard.
// Assumes a single 250 MHz peripheral clock and software-facing plain ports.
`default_nettype none

package out_guard_pkg;

  // Request inputs: four general ones plus the channel 0 request
  localparam int NUM_REQ = 5;
  localparam int CH0_REQ_IDX = 4;
  // Candidate pins per request input, and width of the pin select
  localparam int PIN_CAND = 3;
  localparam int PIN_SEL_W = 2;

  // Level detection needs this many consecutive low samples
  localparam int LOW_RUN = 16;
  localparam int RUN_CNT_W = 4;
  localparam logic [RUN_CNT_W-1:0] RUN_LAST = RUN_CNT_W'(LOW_RUN - 1);
  localparam logic [RUN_CNT_W-1:0] RUN_RST = 4'h0;

  // Prescaler for the divide-by-8, 16 and 128 sample ticks
  localparam int DIV_W = 7;
  localparam logic [DIV_W-1:0] DIV8_MASK = 7'h07;
  localparam logic [DIV_W-1:0] DIV16_MASK = 7'h0F;
  localparam logic [DIV_W-1:0] DIV128_MASK = 7'h7F;
  localparam logic [DIV_W-1:0] DIV_RST = 7'h00;

  // Idle level of an unselected request pin (requests are active low)
  localparam logic PIN_IDLE = 1'h1;
  // Reset value of every flag and every tri-state force
  localparam logic FLAG_RST = 1'h0;

  // Detection mode per request input
  typedef enum logic [1:0] {
    DET_EDGE = 2'h0,
    DET_LOW8 = 2'h1,
    DET_LOW16 = 2'h3,
    DET_LOW128 = 2'h2
  } det_mode_e;

  // The four channel 0 I/O pins
  typedef struct packed {
    logic io_a;
    logic io_b;
    logic io_c;
    logic io_d;
  } ch0_pins_s;

  // The three complementary output pairs
  typedef struct packed {
    logic ch4_bd;
    logic ch4_ac;
    logic ch3_bd;
  } pair_sel_s;

  // The six channel 3 and 4 output pins
  typedef struct packed {
    logic ch3_out_b;
    logic ch3_out_d;
    logic ch4_out_a;
    logic ch4_out_c;
    logic ch4_out_b;
    logic ch4_out_d;
  } ch34_pins_s;

  // Status flags; the same layout carries clear strobes
  typedef struct packed {
    logic short_flag;
    logic osc_stop_flag;
    logic ch0_req;
    logic [3:0] req;
  } guard_status_s;

endpackage

`default_nettype wire

//--- core/fault_req_detect.sv
// One request-input detector: synchroniser, edge or low-level run detection
// and a sticky request flag. Expects the sample ticks as one-cycle pulses.
`default_nettype none

module fault_req_detect (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic pin_in,
  input wire out_guard_pkg::det_mode_e mode_in,
  input wire logic tick8_in,
  input wire logic tick16_in,
  input wire logic tick128_in,
  input wire logic clear_in,
  output logic flag_out
);

  logic sync1_r; // First synchroniser stage, read only by sync2_r
  logic sync2_r; // Synchronised pin level
  logic prev_r; // Previous level, for falling edges
  logic [out_guard_pkg::RUN_CNT_W-1:0] run_r; // Low sample run length
  logic flag_r; // Sticky request flag
  logic [out_guard_pkg::RUN_CNT_W-1:0] run_nxt;
  logic flag_nxt;
  logic tick; // Selected sample tick
  logic hit; // Request detected this cycle
  logic clear_ok; // Clear allowed this cycle

  // Next-state logic for run counter and flag
  always_comb begin
    unique case (mode_in)
      out_guard_pkg::DET_LOW8: tick = tick8_in;
      out_guard_pkg::DET_LOW16: tick = tick16_in;
      out_guard_pkg::DET_LOW128: tick = tick128_in;
      out_guard_pkg::DET_EDGE: tick = 1'h0;
    endcase
    run_nxt = run_r;
    hit = 1'h0;
    if (mode_in == out_guard_pkg::DET_EDGE) begin
      // Falling edge on the synchronised level
      hit = prev_r & ~sync2_r;
      run_nxt = out_guard_pkg::RUN_RST;
    end else if (tick) begin
      if (sync2_r) begin
        // Any high sample restarts the run
        run_nxt = out_guard_pkg::RUN_RST;
      end else if (run_r == out_guard_pkg::RUN_LAST) begin
        // Sixteenth consecutive low sample
        hit = 1'h1;
      end else begin
        run_nxt = run_r + 4'h1;
      end
    end
    // Level mode refuses a clear while the pin still sits low
    clear_ok = (mode_in == out_guard_pkg::DET_EDGE) | sync2_r;
    // Set wins over a clear in the same cycle; flag holds until cleared
    flag_nxt = hit | (flag_r & ~(clear_in & clear_ok));
  end

  // Registers; synchroniser first stage feeds only the second
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_r <= out_guard_pkg::PIN_IDLE;
      sync2_r <= out_guard_pkg::PIN_IDLE;
      prev_r <= out_guard_pkg::PIN_IDLE;
      run_r <= out_guard_pkg::RUN_RST;
      flag_r <= out_guard_pkg::FLAG_RST;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      run_r <= run_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign flag_out = flag_r;

endmodule // fault_req_detect

`default_nettype wire

//--- core/timer_output_disable_guard.sv
// Output protection guard: forces selected timer output pins to high
// impedance on the channel 0 request, oscillation stop or output pair shorts.
// Assumes all inputs synchronous to clk_in except the request pins, which
// are synchronised inside each detector; controls are plain ports.
//
// Behaviour
// - Falling edge or sixteen low samples detect
// - Each request input picks its source pin
// - Channel 0 request tri-states chosen channel 0 pins
// - Per-pin select gates every channel 0 tri-state
// - Oscillation stop tri-states chosen channel 0, 3, 4
// - Pair short tri-states all chosen channel 3, 4
// - Per-pair select gates every channel 3, 4 tri-state
// - Oscillation stop flag readable in status
// - Interrupts on general requests and on shorts
// - Level flag clear ignored while input low
// - Software forces and releases tri-state per group
`default_nettype none

module timer_output_disable_guard #(
  parameter int NUM_REQ = out_guard_pkg::NUM_REQ
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Candidate pins per request input, active low
  input wire logic [1:0] fault_req_in0_pins_in,
  input wire logic [1:0] fault_req_in1_pins_in,
  input wire logic [1:0] fault_req_in2_pins_in,
  input wire logic [1:0] fault_req_in3_pins_in,
  input wire logic [2:0] fault_req_ch0_pins_in,
  // Pin choice per request input, index 4 is the channel 0 request
  input wire logic [NUM_REQ-1:0][1:0] req_pin_sel_in,
  input wire out_guard_pkg::det_mode_e [NUM_REQ-1:0] req_mode_in,
  // Response enables and pin selects
  input wire logic ch0_req_response_en_in,
  input wire out_guard_pkg::ch0_pins_s ch0_pin_sel_in,
  input wire logic osc_stop_response_en_in,
  input wire logic osc_stop_detect_in,
  input wire logic short_response_en_in,
  input wire out_guard_pkg::pair_sel_s pair_sel_in,
  // Timer output levels for pair short detection, active high
  input wire out_guard_pkg::ch34_pins_s ch34_level_in,
  // Software tri-state force and release strobes
  input wire logic sw_hiz_ch34_on_in,
  input wire logic sw_hiz_ch34_off_in,
  input wire logic sw_hiz_ch0_on_in,
  input wire logic sw_hiz_ch0_off_in,
  // Flag clear strobes, one per status bit
  input wire out_guard_pkg::guard_status_s flag_clear_in,
  input wire logic irq_req_en_in,
  input wire logic irq_short_en_in,
  output out_guard_pkg::guard_status_s status_out,
  output out_guard_pkg::ch0_pins_s ch0_hiz_out,
  output out_guard_pkg::ch34_pins_s ch34_hiz_out,
  output logic irq_req_out,
  output logic irq_short_out
);

  // Picks one candidate pin; a select past the candidates reads idle
  function automatic logic pick_pin(input logic [out_guard_pkg::PIN_CAND-1:0] pins,
                                    input logic [out_guard_pkg::PIN_SEL_W-1:0] sel);
    logic res;
    res = out_guard_pkg::PIN_IDLE;
    if (sel < 2'h3) begin
      res = pins[sel];
    end
    return res;
  endfunction

  logic [out_guard_pkg::DIV_W-1:0] div_r; // Free-running prescaler
  logic [out_guard_pkg::DIV_W-1:0] div_nxt;
  logic tick8_r; // Divide-by-8 sample tick
  logic tick16_r; // Divide-by-16 sample tick
  logic tick128_r; // Divide-by-128 sample tick
  logic tick8_nxt;
  logic tick16_nxt;
  logic tick128_nxt;
  logic [NUM_REQ-1:0] req_pin; // Selected request pin per input
  logic [NUM_REQ-1:0] req_flag; // Sticky request flags
  logic osc_flag_r; // Oscillation stop flag
  logic short_flag_r; // Pair short flag
  logic sw_ch34_r; // Software force, channels 3 and 4
  logic sw_ch0_r; // Software force, channel 0
  logic osc_flag_nxt;
  logic short_flag_nxt;
  logic sw_ch34_nxt;
  logic sw_ch0_nxt;
  logic short_now; // Some selected pair drives both sides
  out_guard_pkg::guard_status_s status_r;
  out_guard_pkg::guard_status_s status_nxt;
  out_guard_pkg::ch0_pins_s ch0_hiz_r;
  out_guard_pkg::ch0_pins_s ch0_hiz_nxt;
  out_guard_pkg::ch34_pins_s ch34_hiz_r;
  out_guard_pkg::ch34_pins_s ch34_hiz_nxt;
  logic irq_req_r;
  logic irq_short_r;
  logic irq_req_nxt;
  logic irq_short_nxt;
  logic ch0_force; // Any cause for channel 0 tri-state
  logic ch34_force; // Any cause for channel 3, 4 tri-state

  // Source pin choice; two-pin inputs pad the third candidate idle
  always_comb begin
    req_pin[0] = pick_pin({out_guard_pkg::PIN_IDLE, fault_req_in0_pins_in},
                          req_pin_sel_in[0]);
    req_pin[1] = pick_pin({out_guard_pkg::PIN_IDLE, fault_req_in1_pins_in},
                          req_pin_sel_in[1]);
    req_pin[2] = pick_pin({out_guard_pkg::PIN_IDLE, fault_req_in2_pins_in},
                          req_pin_sel_in[2]);
    req_pin[3] = pick_pin({out_guard_pkg::PIN_IDLE, fault_req_in3_pins_in},
                          req_pin_sel_in[3]);
    req_pin[4] = pick_pin(fault_req_ch0_pins_in, req_pin_sel_in[4]);
  end

  // Prescaler next state and sample ticks
  always_comb begin
    div_nxt = div_r + 7'h01;
    tick8_nxt = (div_r & out_guard_pkg::DIV8_MASK) == out_guard_pkg::DIV8_MASK;
    tick16_nxt = (div_r & out_guard_pkg::DIV16_MASK) == out_guard_pkg::DIV16_MASK;
    tick128_nxt = div_r == out_guard_pkg::DIV128_MASK;
  end

  // Prescaler registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_r <= out_guard_pkg::DIV_RST;
      tick8_r <= 1'h0;
      tick16_r <= 1'h0;
      tick128_r <= 1'h0;
    end else begin
      div_r <= div_nxt;
      tick8_r <= tick8_nxt;
      tick16_r <= tick16_nxt;
      tick128_r <= tick128_nxt;
    end
  end

  // One detector per request input
  for (genvar i = 0; i < NUM_REQ; i++) begin : g_det
    fault_req_detect u_det (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .pin_in(req_pin[i]),
      .mode_in(req_mode_in[i]),
      .tick8_in(tick8_r),
      .tick16_in(tick16_r),
      .tick128_in(tick128_r),
      .clear_in(i == out_guard_pkg::CH0_REQ_IDX ? flag_clear_in.ch0_req
                                                : flag_clear_in.req[i % 4]),
      .flag_out(req_flag[i])
    );
  end

  // Oscillation stop, short and software force next state
  always_comb begin
    // A short is both outputs of a selected pair active together
    short_now = (pair_sel_in.ch3_bd & ch34_level_in.ch3_out_b & ch34_level_in.ch3_out_d)
              | (pair_sel_in.ch4_ac & ch34_level_in.ch4_out_a & ch34_level_in.ch4_out_c)
              | (pair_sel_in.ch4_bd & ch34_level_in.ch4_out_b & ch34_level_in.ch4_out_d);
    // Set wins over a clear in the same cycle
    osc_flag_nxt = osc_stop_detect_in | (osc_flag_r & ~flag_clear_in.osc_stop_flag);
    short_flag_nxt = short_now | (short_flag_r & ~flag_clear_in.short_flag);
    // Force wins if both strobes arrive together, the safe side
    sw_ch34_nxt = sw_hiz_ch34_on_in | (sw_ch34_r & ~sw_hiz_ch34_off_in);
    sw_ch0_nxt = sw_hiz_ch0_on_in | (sw_ch0_r & ~sw_hiz_ch0_off_in);
  end

  // Event and force registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      osc_flag_r <= out_guard_pkg::FLAG_RST;
      short_flag_r <= out_guard_pkg::FLAG_RST;
      sw_ch34_r <= out_guard_pkg::FLAG_RST;
      sw_ch0_r <= out_guard_pkg::FLAG_RST;
    end else begin
      osc_flag_r <= osc_flag_nxt;
      short_flag_r <= short_flag_nxt;
      sw_ch34_r <= sw_ch34_nxt;
      sw_ch0_r <= sw_ch0_nxt;
    end
  end

  // Output next state: tri-state forces, status and interrupts
  always_comb begin
    ch0_force = (ch0_req_response_en_in & req_flag[out_guard_pkg::CH0_REQ_IDX])
              | sw_ch0_r
              | (osc_stop_response_en_in & osc_flag_r);
    ch34_force = (short_response_en_in & short_flag_r)
               | sw_ch34_r
               | (osc_stop_response_en_in & osc_flag_r);
    // Only selected pins follow the force
    ch0_hiz_nxt = ch0_force ? ch0_pin_sel_in : '0;
    ch34_hiz_nxt.ch3_out_b = ch34_force & pair_sel_in.ch3_bd;
    ch34_hiz_nxt.ch3_out_d = ch34_force & pair_sel_in.ch3_bd;
    ch34_hiz_nxt.ch4_out_a = ch34_force & pair_sel_in.ch4_ac;
    ch34_hiz_nxt.ch4_out_c = ch34_force & pair_sel_in.ch4_ac;
    ch34_hiz_nxt.ch4_out_b = ch34_force & pair_sel_in.ch4_bd;
    ch34_hiz_nxt.ch4_out_d = ch34_force & pair_sel_in.ch4_bd;
    status_nxt.short_flag = short_flag_r;
    status_nxt.osc_stop_flag = osc_flag_r;
    status_nxt.ch0_req = req_flag[out_guard_pkg::CH0_REQ_IDX];
    status_nxt.req = req_flag[3:0];
    // Level interrupts follow the flags until they are cleared
    irq_req_nxt = irq_req_en_in & (|req_flag[3:0]);
    irq_short_nxt = irq_short_en_in & short_flag_r;
  end

  // Output registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ch0_hiz_r <= '0;
      ch34_hiz_r <= '0;
      status_r <= '0;
      irq_req_r <= out_guard_pkg::FLAG_RST;
      irq_short_r <= out_guard_pkg::FLAG_RST;
    end else begin
      ch0_hiz_r <= ch0_hiz_nxt;
      ch34_hiz_r <= ch34_hiz_nxt;
      status_r <= status_nxt;
      irq_req_r <= irq_req_nxt;
      irq_short_r <= irq_short_nxt;
    end
  end

  assign ch0_hiz_out = ch0_hiz_r;
  assign ch34_hiz_out = ch34_hiz_r;
  assign status_out = status_r;
  assign irq_req_out = irq_req_r;
  assign irq_short_out = irq_short_r;

endmodule // timer_output_disable_guard

`default_nettype wire

//--- test/fault_pin_model.sv
// Far-side model: fault request pins and timer output pair levels.
// Assumes the bench changes its commands just after the falling edge.
`default_nettype none
module fault_pin_model (
  input wire logic clk_in,
  input wire logic [4:0] req_low_in,
  input wire logic stray_in,
  input wire logic [4:0][1:0] sel_in,
  input wire logic [2:0] short_in,
  output logic [4:0][2:0] pins_out,
  output out_guard_pkg::ch34_pins_s lvl_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph_r = 1'b0; // Pair phase, flips every cycle so no level looks stuck
  always_ff @(posedge clk_in) begin
    ph_r <= ~ph_r;
  end
  // Pull-ups keep idle pins high; a request pulls one candidate low
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      pins_out[k] = 3'h7;
      if (req_low_in[k]) begin
        pins_out[k][sel_in[k] ^ {1'b0, stray_in}] = 1'b0;
      end
    end
    // Pairs stay complementary unless a short is commanded
    lvl_out = {short_in[0] ? 2'h3 : {ph_r, ~ph_r}, short_in[1] ? 2'h3 : {ph_r, ~ph_r},
               short_in[2] ? 2'h3 : {ph_r, ~ph_r}};
  end
endmodule // fault_pin_model
`default_nettype wire

//--- test/guard_checker_assertions.sv
// Checker on the guard's ports: tri-state gating, flags and the request interrupt.
// Assumes one clock domain and the bind in the bench top file.
`default_nettype none
module guard_checker (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire out_guard_pkg::ch0_pins_s ch0_pin_sel_in,
  input wire logic ch0_req_response_en_in,
  input wire logic osc_stop_response_en_in,
  input wire logic osc_stop_detect_in,
  input wire logic short_response_en_in,
  input wire out_guard_pkg::pair_sel_s pair_sel_in,
  input wire out_guard_pkg::ch34_pins_s ch34_level_in,
  input wire logic sw_hiz_ch0_on_in,
  input wire out_guard_pkg::guard_status_s flag_clear_in,
  input wire logic irq_req_en_in,
  input wire out_guard_pkg::guard_status_s status_out,
  input wire out_guard_pkg::ch0_pins_s ch0_hiz_out,
  input wire out_guard_pkg::ch34_pins_s ch34_hiz_out,
  input wire logic irq_req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  logic [5:0] pin_mask; // Pins of the selected pairs
  logic [5:0] lv; // Levels on selected pairs only
  assign pin_mask = {{2{pair_sel_in.ch3_bd}}, {2{pair_sel_in.ch4_ac}}, {2{pair_sel_in.ch4_bd}}};
  assign lv = 6'(ch34_level_in) & pin_mask;
  property p_ch0_gate;
    (ch0_hiz_out & ~$past(ch0_pin_sel_in)) == 4'h0;
  endproperty
  a_ch0_gate: assert property (p_ch0_gate) else $error("ch0 unselected pin tri-stated");
  property p_pair_gate;
    (ch34_hiz_out & ~$past(pin_mask)) == 6'h00;
  endproperty
  a_pair_gate: assert property (p_pair_gate) else $error("unselected pair tri-stated");
  property p_ch0_req;
    status_out.ch0_req && $past(ch0_req_response_en_in) |->
      (ch0_hiz_out & $past(ch0_pin_sel_in)) == $past(ch0_pin_sel_in);
  endproperty
  a_ch0_req: assert property (p_ch0_req) else $error("ch0 request not tri-stating");
  property p_osc_hiz;
    status_out.osc_stop_flag && $past(osc_stop_response_en_in) |->
      ((ch0_hiz_out & $past(ch0_pin_sel_in)) == $past(ch0_pin_sel_in)) &&
      ((ch34_hiz_out & $past(pin_mask)) == $past(pin_mask));
  endproperty
  a_osc_hiz: assert property (p_osc_hiz) else $error("osc stop not tri-stating");
  property p_short_hiz;
    status_out.short_flag && $past(short_response_en_in) |->
      (ch34_hiz_out & $past(pin_mask)) == $past(pin_mask);
  endproperty
  a_short_hiz: assert property (p_short_hiz) else $error("short not tri-stating");
  property p_osc_flag;
    osc_stop_detect_in && osc_stop_response_en_in |-> ##2 status_out.osc_stop_flag;
  endproperty
  a_osc_flag: assert property (p_osc_flag) else $error("osc stop flag missing");
  property p_irq_req;
    irq_req_out == ((|status_out.req) && $past(irq_req_en_in));
  endproperty
  a_irq_req: assert property (p_irq_req) else $error("request irq wrong");
  property p_sw_ch0;
    sw_hiz_ch0_on_in |-> ##2 (ch0_hiz_out & $past(ch0_pin_sel_in)) == $past(ch0_pin_sel_in);
  endproperty
  a_sw_ch0: assert property (p_sw_ch0) else $error("ch0 software force missing");
  property p_flag_hold;
    ($past(status_out) & ~status_out & ~$past(flag_clear_in, 2)) == 7'h00;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag fell without clear");
  property p_short_flag;
    short_response_en_in && ((lv[5] & lv[4]) | (lv[3] & lv[2]) | (lv[1] & lv[0])) |->
      ##2 status_out.short_flag;
  endproperty
  a_short_flag: assert property (p_short_flag) else $error("short flag missing");
endmodule // guard_checker
`default_nettype wire

//--- test/test_timer_output_disable_guard.sv
// Bench for the guard: drives controls and the pin model, checks flags and tri-states.
// Assumes the far-side model and checker files are compiled first.
`default_nettype none
module test_timer_output_disable_guard;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [4:0] req_low = 5'h00; // Requests pulled low by the model
  logic stray = 1'b0; // Pull the unselected candidate instead
  logic [2:0] short_cmd = 3'h0;
  logic [4:0][1:0] req_pin_sel = '0;
  out_guard_pkg::det_mode_e [4:0] req_mode;
  logic ch0_en = 1'b1;
  logic osc_en = 1'b0;
  logic osc_det = 1'b0;
  logic short_en = 1'b0;
  out_guard_pkg::ch0_pins_s ch0_sel = 4'hA; // Only used pins selected
  out_guard_pkg::pair_sel_s pair_sel = 3'h5; // Only used pairs selected
  logic [3:0] sw = 4'h0; // Strobes: ch34 on, ch34 off, ch0 on, ch0 off
  out_guard_pkg::guard_status_s clr = 7'h00;
  logic [1:0] irq_en = 2'h3;
  logic [4:0][2:0] pins;
  out_guard_pkg::ch34_pins_s lvl;
  out_guard_pkg::guard_status_s status;
  out_guard_pkg::ch0_pins_s hiz0;
  out_guard_pkg::ch34_pins_s hiz34;
  logic irq_req;
  logic irq_short;
  int miscompares = 0;
  int total_checks = 0;
  int cyc;
  int divs[3] = '{8, 16, 128};
  logic [15:0] exp_sw[4] = '{16'h33, 16'h0, 16'hA, 16'h0};
  initial forever #2 clk_in = ~clk_in;
  fault_pin_model far_u (.clk_in, .req_low_in(req_low), .stray_in(stray), .sel_in(req_pin_sel),
    .short_in(short_cmd), .pins_out(pins), .lvl_out(lvl));
  timer_output_disable_guard dut_u (.clk_in, .reset_n_in,
    .fault_req_in0_pins_in(pins[0][1:0]), .fault_req_in1_pins_in(pins[1][1:0]),
    .fault_req_in2_pins_in(pins[2][1:0]), .fault_req_in3_pins_in(pins[3][1:0]),
    .fault_req_ch0_pins_in(pins[4]), .req_pin_sel_in(req_pin_sel), .req_mode_in(req_mode),
    .ch0_req_response_en_in(ch0_en), .ch0_pin_sel_in(ch0_sel),
    .osc_stop_response_en_in(osc_en), .osc_stop_detect_in(osc_det),
    .short_response_en_in(short_en), .pair_sel_in(pair_sel), .ch34_level_in(lvl),
    .sw_hiz_ch34_on_in(sw[3]), .sw_hiz_ch34_off_in(sw[2]), .sw_hiz_ch0_on_in(sw[1]),
    .sw_hiz_ch0_off_in(sw[0]), .flag_clear_in(clr), .irq_req_en_in(irq_en[1]),
    .irq_short_en_in(irq_en[0]), .status_out(status), .ch0_hiz_out(hiz0),
    .ch34_hiz_out(hiz34), .irq_req_out(irq_req), .irq_short_out(irq_short));
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Bounded wait for one status bit; running out ends the run
  task automatic wait_flag(input int b, input int lim);
    cyc = 0;
    while (status[b] !== 1'b1 && cyc < lim) begin
      tick(1);
      cyc++;
    end
    if (cyc >= lim) begin
      miscompares++;
      $display("[FAIL] status bit %0d expected 1 seen 0", b);
      close_out();
    end
  endtask
  // Strobe every clear, then let the outputs settle
  task automatic clear_all();
    tick(3);
    clr = 7'h7F;
    tick(1);
    clr = 7'h00;
    tick(3);
  endtask
  initial begin
    for (int k = 0; k < 5; k++) req_mode[k] = out_guard_pkg::DET_EDGE;
    tick(2);
    reset_n_in = 1'b1;
    chk("status after reset", 16'h0, 16'(status));
    // Edge mode on every input, each from its own candidate pin
    for (int k = 0; k < 5; k++) begin
      req_pin_sel[k] = 2'(k % 2);
      stray = 1'b1;
      req_low[k] = 1'b1;
      tick(6);
      chk("stray pin", 16'((1 << k) - 1), 16'(status));
      stray = 1'b0;
      wait_flag(k, 6);
    end
    tick(2);
    chk("held flags", 16'h1F, 16'(status));
    chk("ch0 request", 16'hA, 16'(hiz0));
    chk("request irq", 16'h1, 16'(irq_req));
    req_low = 5'h00;
    clear_all();
    chk("cleared", 16'h0, 16'(16'(status) | 16'(hiz0)));
    // Responses off: flags still latch, no tri-state and no interrupt
    ch0_en = 1'b0;
    irq_en = 2'h0;
    req_low = 5'h11;
    tick(6);
    chk("flags, response off", 16'h11, 16'(status));
    chk("ch0 response off", 16'h0, 16'(hiz0));
    chk("irq off", 16'h0, 16'({irq_req, irq_short}));
    req_low = 5'h00;
    clear_all();
    ch0_en = 1'b1;
    irq_en = 2'h3;
    // Low-level runs: a high sample restarts, clear refused while low
    for (int i = 0; i < 3; i++) begin
      req_mode[1] = i == 0 ? out_guard_pkg::DET_LOW8 :
                    (i == 1 ? out_guard_pkg::DET_LOW16 : out_guard_pkg::DET_LOW128);
      req_low[1] = 1'b1;
      tick(8 * divs[i]);
      req_low[1] = 1'b0;
      tick(2 * divs[i]);
      req_low[1] = 1'b1;
      tick(15 * divs[i] - 4);
      chk("run restarted", 16'h0, 16'(status));
      wait_flag(1, 2 * divs[i] + 8);
      clr = 7'h7F;
      tick(1);
      clr = 7'h00;
      tick(3);
      chk("clear while low", 16'h2, 16'(status));
      req_low[1] = 1'b0;
      // A run stuck at its last count re-flags at once unless a high sample lands
      tick(2 * divs[i]);
      clear_all();
      chk("clear after release", 16'h0, 16'(status));
    end
    // Software force and release per group
    for (int j = 0; j < 4; j++) begin
      sw = 4'h8 >> j;
      tick(1);
      sw = 4'h0;
      tick(2);
      chk("software force", exp_sw[j], j < 2 ? 16'(hiz34) : 16'(hiz0));
    end
    short_en = 1'b1;
    short_cmd = 3'h2;
    tick(4);
    chk("unselected short", 16'h0, 16'(status));
    short_cmd = 3'h1;
    tick(4);
    chk("short flag", 16'h40, 16'(status));
    chk("short tri-state", 16'h33, 16'(hiz34));
    chk("short irq", 16'h1, 16'(irq_short));
    short_cmd = 3'h0;
    clear_all();
    osc_en = 1'b1;
    osc_det = 1'b1;
    tick(1);
    osc_det = 1'b0;
    tick(3);
    chk("osc flag", 16'h20, 16'(status));
    chk("osc ch0", 16'hA, 16'(hiz0));
    chk("osc ch34", 16'h33, 16'(hiz34));
    reset_n_in = 1'b0;
    tick(2);
    chk("flags in reset", 16'h0, 16'(status));
    reset_n_in = 1'b1;
    tick(2);
    close_out();
  end
endmodule // test_timer_output_disable_guard
bind timer_output_disable_guard guard_checker chk_u (.clk_in, .reset_n_in, .ch0_pin_sel_in,
  .ch0_req_response_en_in, .osc_stop_response_en_in, .osc_stop_detect_in,
  .short_response_en_in, .pair_sel_in, .ch34_level_in, .sw_hiz_ch0_on_in, .flag_clear_in,
  .irq_req_en_in, .status_out, .ch0_hiz_out, .ch34_hiz_out, .irq_req_out);
`default_nettype wire
